/* hw/lcr_params.svh */
// Purpose: Named offsets, field positions, reset values and timing for the lane slice.
// Assumes: Eight-bit register port, 250 MHz register clock.
// Notes: Definitions only; included by bare name.
`ifndef LCR_PARAMS_SVH
`define LCR_PARAMS_SVH

// ====================================================================
// Register offsets.
`define LCR_OFS_A1_DEEMPH 8'h35
`define LCR_OFS_A1_SDTH 8'h36
`define LCR_OFS_SPARE_A 8'h37
`define LCR_OFS_SPARE_B 8'h38
`define LCR_OFS_A2_RECEIVER_DETECT_MODE 8'h39
`define LCR_OFS_A2_EQ 8'h3a

// ====================================================================
// Field positions.
`define LCR_TERM_BIT 7
`define LCR_DEEMPH_MSB 2
`define LCR_DEEMPH_LSB 0
`define LCR_SDA_MSB 3
`define LCR_SDA_LSB 2
`define LCR_SDD_MSB 1
`define LCR_SDD_LSB 0
`define LCR_RECEIVER_DETECT_MODE_MSB 3
`define LCR_RECEIVER_DETECT_MODE_LSB 2

// ====================================================================
// Reset values.
`define LCR_RST_DEEMPH 3'h2
`define LCR_RST_SD 2'h0
`define LCR_RST_SPARE 8'h00
`define LCR_RST_RECEIVER_DETECT_MODE 2'h0
`define LCR_RST_EQ 8'h2f
`define LCR_RST_BYTE 8'h00

// ====================================================================
// Receiver-detect codes and timing.
`define LCR_RECEIVER_DETECT_MODE_HIZ 2'h0
`define LCR_RECEIVER_DETECT_MODE_LIMITED 2'h1
`define LCR_RECEIVER_DETECT_MODE_ENDLESS 2'h2
`define LCR_RECEIVER_DETECT_MODE_TERM 2'h3
`define LCR_DET_INTERVAL_MS 12
`define LCR_CLK_MHZ 250
`define LCR_DET_INTERVAL_CYC (`LCR_DET_INTERVAL_MS * 1000 * `LCR_CLK_MHZ)
`define LCR_DET_ATTEMPTS 6'h32
`define LCR_TICK_W 22

`endif

/* hw/lcr_pkg.sv */
// Purpose: Types shared by the lane configuration slice.
// Assumes: Nothing beyond the params header.
// Notes: Detection states are one-hot.
package lcr_pkg;

    // ================================================================
    // Receiver-detect engine states.
    typedef enum logic [3:0] {
        LCR_ST_HIZ = 4'h1,
        LCR_ST_WAIT = 4'h2,
        LCR_ST_GAVE_UP = 4'h4,
        LCR_ST_TERM = 4'h8
    } lcr_det_state_e;

endpackage

/* hw/lcr_receiver_detect_mode_engine.sv */
// Purpose: Periodic receiver-detect sequencer for one lane.
// Assumes: Load result is valid in the same cycle as the test pulse.
// Notes: Any mode change restarts the interval and the attempt count.
`timescale 1ns/1ps
`default_nettype none
`include "lcr_params.svh"

module lcr_receiver_detect_mode_engine #(
    parameter int unsigned P_INTERVAL_CYC = `LCR_DET_INTERVAL_CYC
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Effective mode and analog result.
    input wire logic [1:0] i_mode,
    input wire logic i_load_found,
    // Analog controls.
    output logic o_detect_test,
    output logic o_term_50
);

    localparam logic [`LCR_TICK_W-1:0] LC_LAST = `LCR_TICK_W'(P_INTERVAL_CYC - 1);

    lcr_pkg::lcr_det_state_e state, next_state;
    logic [`LCR_TICK_W-1:0] tick, next_tick;
    logic [5:0] attempts, next_attempts;
    logic [1:0] prev_mode, next_prev_mode;
    logic pending, next_pending;
    logic next_test;

    // Next-state logic; a mode change overrides everything else.
    always_comb
    begin
        next_state = state;
        next_tick = tick;
        next_attempts = attempts;
        next_prev_mode = i_mode;
        next_pending = 1'b0;
        next_test = 1'b0;
        if (i_mode != prev_mode)
        begin
            next_tick = '0; // RL13
            next_attempts = '0; // RL13
            case (i_mode)
                `LCR_RECEIVER_DETECT_MODE_HIZ: next_state = lcr_pkg::LCR_ST_HIZ; // RL1
                `LCR_RECEIVER_DETECT_MODE_TERM: next_state = lcr_pkg::LCR_ST_TERM; // RL4
                default: next_state = lcr_pkg::LCR_ST_WAIT;
            endcase
        end
        else
        begin
            case (state)
                lcr_pkg::LCR_ST_WAIT:
                begin
                    if (tick == LC_LAST)
                    begin
                        next_tick = '0;
                        next_test = 1'b1; // RL2 RL3
                        next_pending = 1'b1;
                    end
                    else
                    begin
                        next_tick = tick + 1'b1;
                    end
                    if (pending)
                    begin
                        next_attempts = attempts + 1'b1;
                        if (i_load_found)
                            next_state = lcr_pkg::LCR_ST_TERM; // RL2 RL3
                        else if (i_mode == `LCR_RECEIVER_DETECT_MODE_LIMITED &&
                                 next_attempts == `LCR_DET_ATTEMPTS)
                            next_state = lcr_pkg::LCR_ST_GAVE_UP; // RL2
                        else if (i_mode == `LCR_RECEIVER_DETECT_MODE_ENDLESS)
                            next_attempts = '0; // RL3
                    end
                end
                lcr_pkg::LCR_ST_HIZ: next_state = state;
                lcr_pkg::LCR_ST_GAVE_UP: next_state = state;
                lcr_pkg::LCR_ST_TERM: next_state = state;
                default: next_state = lcr_pkg::LCR_ST_HIZ;
            endcase
        end
    end

    // Registers; after reset the lane is high impedance with no test running.
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            state <= lcr_pkg::LCR_ST_HIZ;
            tick <= '0;
            attempts <= '0;
            prev_mode <= `LCR_RECEIVER_DETECT_MODE_HIZ;
            pending <= 1'b0;
            o_detect_test <= 1'b0;
            o_term_50 <= 1'b0;
        end
        else
        begin
            state <= next_state;
            tick <= next_tick;
            attempts <= next_attempts;
            prev_mode <= next_prev_mode;
            pending <= next_pending;
            o_detect_test <= next_test;
            o_term_50 <= (next_state == lcr_pkg::LCR_ST_TERM);
        end
    end

endmodule
`default_nettype wire

/* hw/lcr_lane_config.sv */
// Purpose: Configuration registers for lanes a1 and a2 of the redriver slice.
// Assumes: A loader or software drives the byte-wide register port.
// Notes: Reserved bit positions read as zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "lcr_params.svh"

// Function
// RL1: Code zero keeps input high impedance, no detection.
// RL2: Code one tests every 12 ms, 50 times.
// RL3: Code two tests every 12 ms until found.
// RL4: Code three terminates 50 ohm without testing.
// RL5: Register mode applies only under global override.
// RL6: Bit seven reports termination state, read-only.
// RL7: Three-bit de-emphasis field, reset code 010.
// RL8: Two-bit assert threshold field, reset code 00.
// RL9: Two-bit de-assert threshold field, reset code 00.
// RL10: Threshold fields apply only under global override.
// RL11: Equalizer byte read-write, reset 0x2F.
// RL12: Software writes zero to reserved bits.
// RL13: Mode change restarts interval and attempt counter.
module lcr_lane_config #(
    parameter int unsigned P_DET_INTERVAL_CYC = `LCR_DET_INTERVAL_CYC
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Register port.
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr_en,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd_en,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rd_valid,
    // Global override bits and pin straps.
    input wire logic i_override_receiver_detect,
    input wire logic i_override_signal_detect,
    input wire logic [1:0] i_pin_receiver_detect_mode,
    input wire logic [1:0] i_pin_sd_assert_threshold,
    input wire logic [1:0] i_pin_sd_deassert_threshold,
    // Lane a1 receiver-detect mode held outside this slice.
    input wire logic [1:0] i_lane_a1_receiver_detect_mode,
    // Analog load-detect results.
    input wire logic i_lane_a1_load_found,
    input wire logic i_lane_a2_load_found,
    // Lane a1 analog controls.
    output logic [2:0] o_lane_a1_output_deemphasis,
    output logic [1:0] o_lane_a1_sd_assert_threshold,
    output logic [1:0] o_lane_a1_sd_deassert_threshold,
    output logic o_lane_a1_detect_test,
    output logic o_lane_a1_termination_50,
    // Lane a2 analog controls.
    output logic [7:0] o_lane_a2_equalizer_level,
    output logic o_lane_a2_detect_test,
    output logic o_lane_a2_termination_50
);

    // ================================================================
    // Helpers.

    // Chooses the register field under override, else the pin strap.
    function automatic logic [1:0] lcr_pick(input logic ovr, input logic [1:0] reg_val,
                                            input logic [1:0] pin_val);
        lcr_pick = ovr ? reg_val : pin_val;
    endfunction

    // ================================================================
    // Register state.

    logic [2:0] a1_deemph, next_a1_deemph;
    logic [1:0] a1_sd_assert, next_a1_sd_assert;
    logic [1:0] a1_sd_deassert, next_a1_sd_deassert;
    logic [7:0] spare_a, next_spare_a;
    logic [7:0] spare_b, next_spare_b;
    logic [1:0] a2_receiver_detect_mode, next_a2_receiver_detect_mode;
    logic [7:0] a2_eq, next_a2_eq;

    // Write decode; only the field bits are stored, except the spare registers, which keep the whole byte.
    always_comb
    begin
        next_a1_deemph = a1_deemph;
        next_a1_sd_assert = a1_sd_assert;
        next_a1_sd_deassert = a1_sd_deassert;
        next_spare_a = spare_a;
        next_spare_b = spare_b;
        next_a2_receiver_detect_mode = a2_receiver_detect_mode;
        next_a2_eq = a2_eq;
        if (i_reg_wr_en)
        begin
            case (i_reg_addr)
                `LCR_OFS_A1_DEEMPH:
                    next_a1_deemph = i_reg_wdata[`LCR_DEEMPH_MSB:`LCR_DEEMPH_LSB]; // RL7
                `LCR_OFS_A1_SDTH:
                begin
                    next_a1_sd_assert = i_reg_wdata[`LCR_SDA_MSB:`LCR_SDA_LSB]; // RL8
                    next_a1_sd_deassert = i_reg_wdata[`LCR_SDD_MSB:`LCR_SDD_LSB]; // RL9
                end
                `LCR_OFS_SPARE_A:
                    next_spare_a = i_reg_wdata;
                `LCR_OFS_SPARE_B:
                    next_spare_b = i_reg_wdata;
                `LCR_OFS_A2_RECEIVER_DETECT_MODE:
                    next_a2_receiver_detect_mode = i_reg_wdata[`LCR_RECEIVER_DETECT_MODE_MSB:`LCR_RECEIVER_DETECT_MODE_LSB];
                `LCR_OFS_A2_EQ:
                    next_a2_eq = i_reg_wdata; // RL11
                default:
                    next_a2_eq = a2_eq;
            endcase
        end
    end

    // Field registers with their documented reset codes.
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            a1_deemph <= `LCR_RST_DEEMPH; // RL7
            a1_sd_assert <= `LCR_RST_SD; // RL8
            a1_sd_deassert <= `LCR_RST_SD; // RL9
            spare_a <= `LCR_RST_SPARE;
            spare_b <= `LCR_RST_SPARE;
            a2_receiver_detect_mode <= `LCR_RST_RECEIVER_DETECT_MODE;
            a2_eq <= `LCR_RST_EQ; // RL11
        end
        else
        begin
            a1_deemph <= next_a1_deemph;
            a1_sd_assert <= next_a1_sd_assert;
            a1_sd_deassert <= next_a1_sd_deassert;
            spare_a <= next_spare_a;
            spare_b <= next_spare_b;
            a2_receiver_detect_mode <= next_a2_receiver_detect_mode;
            a2_eq <= next_a2_eq;
        end
    end

    // ================================================================
    // Receiver-detect engines.

    logic [1:0] a1_mode_eff;
    logic [1:0] a2_mode_eff;

    // The strap governs unless software has taken over via the override.
    assign a1_mode_eff = lcr_pick(i_override_receiver_detect,
                                  i_lane_a1_receiver_detect_mode,
                                  i_pin_receiver_detect_mode); // RL5
    assign a2_mode_eff = lcr_pick(i_override_receiver_detect, a2_receiver_detect_mode,
                                  i_pin_receiver_detect_mode); // RL5

    // Lane a1 engine; its state feeds the observation bit.
    lcr_receiver_detect_mode_engine #(
        .P_INTERVAL_CYC(P_DET_INTERVAL_CYC)
    ) u_det_a1 (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_mode(a1_mode_eff),
        .i_load_found(i_lane_a1_load_found),
        .o_detect_test(o_lane_a1_detect_test),
        .o_term_50(o_lane_a1_termination_50)
    );

    // Lane a2 engine, steered by its own mode register.
    lcr_receiver_detect_mode_engine #(
        .P_INTERVAL_CYC(P_DET_INTERVAL_CYC)
    ) u_det_a2 (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_mode(a2_mode_eff),
        .i_load_found(i_lane_a2_load_found),
        .o_detect_test(o_lane_a2_detect_test),
        .o_term_50(o_lane_a2_termination_50)
    );

    // ================================================================
    // Read path.

    logic [7:0] next_rdata;

    // Read mux; unmapped offsets and reserved bits answer zero.
    always_comb
    begin
        next_rdata = `LCR_RST_BYTE;
        case (i_reg_addr)
            `LCR_OFS_A1_DEEMPH:
            begin
                next_rdata[`LCR_DEEMPH_MSB:`LCR_DEEMPH_LSB] = a1_deemph;
                next_rdata[`LCR_TERM_BIT] = o_lane_a1_termination_50; // RL6
            end
            `LCR_OFS_A1_SDTH:
            begin
                next_rdata[`LCR_SDA_MSB:`LCR_SDA_LSB] = a1_sd_assert;
                next_rdata[`LCR_SDD_MSB:`LCR_SDD_LSB] = a1_sd_deassert;
            end
            `LCR_OFS_SPARE_A: next_rdata = spare_a;
            `LCR_OFS_SPARE_B: next_rdata = spare_b;
            `LCR_OFS_A2_RECEIVER_DETECT_MODE: next_rdata[`LCR_RECEIVER_DETECT_MODE_MSB:`LCR_RECEIVER_DETECT_MODE_LSB] = a2_receiver_detect_mode;
            `LCR_OFS_A2_EQ: next_rdata = a2_eq;
            default: next_rdata = `LCR_RST_BYTE;
        endcase
    end

    // Read data is held until the next read so a slow loader can sample it.
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            o_reg_rdata <= `LCR_RST_BYTE;
            o_reg_rd_valid <= 1'b0;
        end
        else
        begin
            o_reg_rd_valid <= i_reg_rd_en;
            if (i_reg_rd_en)
                o_reg_rdata <= next_rdata;
        end
    end

    // ================================================================
    // Analog control outputs.

    logic [1:0] next_sd_assert_eff;
    logic [1:0] next_sd_deassert_eff;

    // Threshold selection; registering it keeps the analog side glitch free
    // when the override bit and the field change in the same cycle.
    always_comb
    begin
        next_sd_assert_eff = lcr_pick(i_override_signal_detect, a1_sd_assert,
                                      i_pin_sd_assert_threshold); // RL10
        next_sd_deassert_eff = lcr_pick(i_override_signal_detect, a1_sd_deassert,
                                        i_pin_sd_deassert_threshold); // RL10
    end

    // Output flops; values lag the field registers by one cycle.
    always_ff @(posedge i_mclk)
    begin
        if (!i_nrst)
        begin
            o_lane_a1_output_deemphasis <= `LCR_RST_DEEMPH;
            o_lane_a1_sd_assert_threshold <= `LCR_RST_SD;
            o_lane_a1_sd_deassert_threshold <= `LCR_RST_SD;
            o_lane_a2_equalizer_level <= `LCR_RST_EQ;
        end
        else
        begin
            o_lane_a1_output_deemphasis <= a1_deemph; // RL7
            o_lane_a1_sd_assert_threshold <= next_sd_assert_eff;
            o_lane_a1_sd_deassert_threshold <= next_sd_deassert_eff;
            o_lane_a2_equalizer_level <= a2_eq; // RL11
        end
    end

endmodule
`default_nettype wire

/* tb/lcr_lane_config_checker.sv */
// Purpose: Port-level assertions for the lane configuration slice.
// Assumes: The bench sets the detect interval to 8 cycles.
// Notes: Bound to the slice below the module.
`timescale 1ns/1ps
`default_nettype none
module lcr_lane_config_checker (
    // Clock, reset and register port.
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr_en,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd_en,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rd_valid,
    // Mode selection.
    input wire logic i_override_receiver_detect,
    input wire logic i_override_signal_detect,
    input wire logic [1:0] i_pin_receiver_detect_mode,
    input wire logic [1:0] i_pin_sd_assert_threshold,
    input wire logic [1:0] i_lane_a1_receiver_detect_mode,
    // Watched outputs.
    input wire logic [2:0] o_lane_a1_output_deemphasis,
    input wire logic [1:0] o_lane_a1_sd_assert_threshold,
    input wire logic o_lane_a1_detect_test,
    input wire logic o_lane_a1_termination_50,
    input wire logic [7:0] o_lane_a2_equalizer_level
);
    // ================================================================
    // Effective lane a1 code; a pin change under override must not count.
    logic [1:0] eff_a1;
    assign eff_a1 = i_override_receiver_detect ? i_lane_a1_receiver_detect_mode
        : i_pin_receiver_detect_mode;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);

    // ================================================================
    // Register port timing and stored copies.
    chk_read_answer: assert property (i_reg_rd_en |=> o_reg_rd_valid)
        else $error("read valid missing");
    chk_read_quiet: assert property (!i_reg_rd_en |=> !o_reg_rd_valid)
        else $error("spurious read valid");
    chk_eq_copy: assert property (i_reg_wr_en && i_reg_addr == 8'h3a
        |-> ##2 o_lane_a2_equalizer_level == $past(i_reg_wdata, 2))
        else $error("equalizer output wrong");
    chk_deemph_copy: assert property (i_reg_wr_en && i_reg_addr == 8'h35
        |-> ##2 o_lane_a1_output_deemphasis == 3'($past(i_reg_wdata, 2)))
        else $error("deemphasis output wrong");
    chk_sd_pin: assert property (!i_override_signal_detect
        |=> o_lane_a1_sd_assert_threshold == $past(i_pin_sd_assert_threshold))
        else $error("threshold ignores pin");
    chk_status_bit: assert property (i_reg_rd_en && i_reg_addr == 8'h35
        |=> o_reg_rdata[7] == $past(o_lane_a1_termination_50))
        else $error("status bit wrong");

    // ================================================================
    // Detection engine of lane a1.
    chk_hiz_idle: assert property ((eff_a1 == 2'h0) [*3]
        |=> !o_lane_a1_termination_50 && !o_lane_a1_detect_test)
        else $error("code zero not idle");
    chk_term_fixed: assert property ((eff_a1 == 2'h3) [*3]
        |=> o_lane_a1_termination_50 && !o_lane_a1_detect_test)
        else $error("code three not terminated");
    chk_test_gap: assert property (o_lane_a1_detect_test
        |=> !o_lane_a1_detect_test [*7])
        else $error("tests too close");
    chk_restart_gap: assert property ($changed(eff_a1)
        |=> !o_lane_a1_detect_test [*7])
        else $error("no restart on change");
    chk_endless_test: assert property ($changed(eff_a1) && eff_a1 == 2'h2
        ##1 (eff_a1 == 2'h2) [*8] ##1 eff_a1 == 2'h2 |-> ##[0:2] o_lane_a1_detect_test)
        else $error("test pulse late");
endmodule
bind lcr_lane_config lcr_lane_config_checker u_chk (.*);
`default_nettype wire

/* tb/tb.sv */
// Purpose: Self-checking bench for the lane configuration slice.
// Assumes: Detect interval shortened to 8 cycles.
// Notes: Random register traffic from a fixed seed plus mode corner cases.
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ================================================================
    // Design signals, named as the ports.
    logic i_mclk = 1'b0;
    logic i_nrst, i_reg_wr_en, i_reg_rd_en, o_reg_rd_valid;
    logic i_override_receiver_detect, i_override_signal_detect;
    logic i_lane_a1_load_found, i_lane_a2_load_found;
    logic o_lane_a1_detect_test, o_lane_a1_termination_50;
    logic o_lane_a2_detect_test, o_lane_a2_termination_50;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_lane_a2_equalizer_level;
    logic [1:0] i_pin_receiver_detect_mode, i_pin_sd_assert_threshold;
    logic [1:0] i_pin_sd_deassert_threshold, i_lane_a1_receiver_detect_mode;
    logic [1:0] o_lane_a1_sd_assert_threshold, o_lane_a1_sd_deassert_threshold;
    logic [2:0] o_lane_a1_output_deemphasis;
    logic [7:0] mir [52:59];
    logic [7:0] r;
    logic [3:0] rg;
    integer seed = 50880;
    int bad_count = 0;
    int checks = 0;
    int c;

    lcr_lane_config #(.P_DET_INTERVAL_CYC(8)) dut (.*);

    initial
    begin
        forever #2 i_mclk = ~i_mclk;
    end

    // ================================================================
    // Shared tasks and expectations.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge i_mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr_en = 1'b1;
        @(negedge i_mclk);
        i_reg_wr_en = 1'b0;
    endtask

    // Data is taken only with the valid pulse, so a late answer shows up as x.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_mclk);
        i_reg_addr = a;
        i_reg_rd_en = 1'b1;
        @(negedge i_mclk);
        i_reg_rd_en = 1'b0;
        d = (o_reg_rd_valid === 1'b1) ? o_reg_rdata : 8'hxx;
    endtask

    task automatic count_tests(input int n, output int k);
        k = 0;
        repeat (n)
        begin
            @(negedge i_mclk);
            if (o_lane_a1_detect_test === 1'b1)
                k++;
        end
    endtask

    function automatic logic [7:0] wmask(input int a);
        case (a)
            53: return 8'h07;
            54: return 8'h0f;
            57: return 8'h0c;
            58: return 8'hff;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] pick(input logic ov, input logic [1:0] rv, input logic [1:0] pv);
        return {6'h00, ov ? rv : pv};
    endfunction

    task automatic end_of_test();
        $display("Counts: checks=%0d mismatches=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ================================================================
    // Main sequence.
    initial
    begin
        i_nrst = 1'b0;
        i_reg_wr_en = 1'b0;
        i_reg_rd_en = 1'b0;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        i_override_receiver_detect = 1'b1;
        i_override_signal_detect = 1'b1;
        i_lane_a1_load_found = 1'b0;
        i_lane_a2_load_found = 1'b0;
        i_pin_receiver_detect_mode = 2'h0;
        i_pin_sd_assert_threshold = 2'h0;
        i_pin_sd_deassert_threshold = 2'h0;
        i_lane_a1_receiver_detect_mode = 2'h0;
        for (int a = 52; a <= 59; a++)
            mir[a] = 8'h00;
        mir[53] = 8'h02;
        mir[58] = 8'h2f;
        tick(10);
        i_nrst = 1'b1;
        for (int a = 52; a <= 59; a++)
        begin
            rd(8'(a), r);
            check(r, mir[a]);
        end
        check({5'h00, o_lane_a1_output_deemphasis}, 8'h02);
        check({4'h0, o_lane_a1_sd_assert_threshold, o_lane_a1_sd_deassert_threshold}, 8'h00);
        $display("Test reset values done");
        // Random writes keep reserved bits and reserved registers at zero.
        for (int n = 0; n < 48; n++)
        begin
            c = 52 + ($random(seed) & 7);
            wr(8'(c), 8'($random(seed)) & wmask(c));
            mir[c] = i_reg_wdata;
            rd(8'(c), r);
            check(r, mir[c]);
            check(o_lane_a2_equalizer_level, mir[58]);
            check({5'h00, o_lane_a1_output_deemphasis}, mir[53]);
        end
        $display("Test random registers done");
        for (int n = 0; n < 16; n++)
        begin
            rg = {~n[2:1], n[2:1]};
            i_override_signal_detect = n[0];
            i_pin_sd_assert_threshold = n[2:1];
            i_pin_sd_deassert_threshold = ~n[2:1];
            wr(8'h36, {4'h0, rg});
            tick(2);
            check({6'h00, o_lane_a1_sd_assert_threshold}, pick(n[0], rg[3:2], n[2:1]));
            check({6'h00, o_lane_a1_sd_deassert_threshold}, pick(n[0], rg[1:0], ~n[2:1]));
        end
        $display("Test thresholds done");
        i_lane_a1_receiver_detect_mode = 2'h3;
        tick(4);
        rd(8'h35, r);
        check({7'h00, r[7]}, 8'h01);
        count_tests(30, c);
        check({7'h00, o_lane_a1_termination_50}, 8'(c == 0));
        i_lane_a1_receiver_detect_mode = 2'h0;
        count_tests(30, c);
        check({7'h00, o_lane_a1_termination_50}, 8'(c));
        i_lane_a1_receiver_detect_mode = 2'h2;
        count_tests(100, c);
        check(8'(c), 8'h0c);
        i_lane_a1_load_found = 1'b1;
        tick(20);
        check({7'h00, o_lane_a1_termination_50}, 8'h01);
        i_lane_a1_load_found = 1'b0;
        // A change in mid-run must give a fresh set of attempts.
        i_lane_a1_receiver_detect_mode = 2'h1;
        count_tests(150, c);
        i_lane_a1_receiver_detect_mode = 2'h2;
        tick(3);
        i_lane_a1_receiver_detect_mode = 2'h1;
        count_tests(900, c);
        check(8'(c), 8'h32);
        check({7'h00, o_lane_a1_termination_50}, 8'h00);
        $display("Test detect engine done");
        wr(8'h39, 8'h00);
        i_override_receiver_detect = 1'b0;
        i_pin_receiver_detect_mode = 2'h3;
        tick(4);
        check({6'h00, o_lane_a2_termination_50, o_lane_a1_termination_50}, 8'h03);
        i_override_receiver_detect = 1'b1;
        i_lane_a1_receiver_detect_mode = 2'h0;
        tick(4);
        check({6'h00, o_lane_a2_termination_50, o_lane_a1_termination_50}, 8'h00);
        // Lane a2 in endless mode must pulse twice within twenty cycles.
        wr(8'h39, 8'h08);
        c = 0;
        repeat (20)
        begin
            @(negedge i_mclk);
            c += int'(o_lane_a2_detect_test === 1'b1);
        end
        check(8'(c), 8'h02);
        $display("Test override done");
        end_of_test();
    end

    // Run needs about 1550 cycles; five times that means a hang.
    initial
    begin
        #32000;
        bad_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
